// ### hdl/dtc_top.sv
// DRAM on-die termination control with AHB-Lite register access
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
module dtc_top (
   // System clock and reset
   input  wire logic                hclk,
   input  wire logic                hresetn,
   // AHB-Lite slave
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic                     hreadyout,
   output logic                     hresp,
   output logic [31:0]              hrdata,
   // Command link from the memory controller
   input  wire logic                cmd_clk,
   input  wire logic                odt_pin,
   input  wire dtc_pkg::dtc_cmd_s   cmd,
   // Termination outputs
   output dtc_pkg::dtc_lanes_s      lanes,
   output dtc_pkg::dtc_term_e       term_state,
   output logic [2:0]               term_code,
   output logic                     odt_rx_en
);
   import dtc_pkg::*;

   logic [MODE_W-1:0]     mode_register_one_q;
   logic [MODE_W-1:0]     mode_register_two_q;
   logic [MODE_W-1:0]     mode_register_five_q;
   logic [CTRL_W-1:0]     ctrl_q;
   logic [LAT_W-1:0]      write_latency_q;
   logic [LAT_W-1:0]      read_latency_q;
   logic                  dph_wr_q;
   logic [7:0]            dph_addr_q;
   logic [31:0]           rdata_q;
   logic                  ck_s1_q;
   logic                  ck_s2_q;
   logic                  ck_s3_q;
   logic                  odt_s1_q;
   logic                  odt_s2_q;
   dtc_cmd_s              cmd_s1_q;
   dtc_cmd_s              cmd_s2_q;
   logic [HIST_DEPTH-1:0] odt_hist_q;
   logic [HIST_DEPTH-1:0] rd_hist_q;
   logic [HIST_DEPTH-1:0] wr_hist_q;
   dtc_term_e             state_q;
   logic [2:0]            code_q;
   dtc_lanes_s            lanes_q;
   logic                  rx_en_q;
   logic                  ck_rise;
   logic                  addr_phase;
   logic [2:0]            nom_code;
   logic [2:0]            wr_code;
   logic [2:0]            park_code;
   logic                  self_ref;
   logic                  nom_en;
   logic                  wr_en;
   logic                  park_en;
   logic                  term_enabled;
   logic                  pin_ok;
   logic [7:0]            x_adj;
   logic [7:0]            half_burst;
   logic [7:0]            dodtl;
   logic [7:0]            rd_start;
   logic [7:0]            win_len;
   logic                  nom_on;
   logic                  rd_win;
   logic                  wr_win;
   dtc_term_e             sel_state;
   logic [2:0]            sel_code;
   logic [31:0]           status_word;
   logic [31:0]           rd_mux;

   // Decoded configuration
   assign nom_code   = mode_register_one_q[NOM_LSB +: FIELD_W];
   assign wr_code    = mode_register_two_q[WR_LSB +: FIELD_W];
   assign park_code  = mode_register_five_q[PARK_LSB +: FIELD_W];
   assign self_ref   = ctrl_q[CTRL_SR_BIT];
   // Write field codes above 3 (WR_CODE_MAX) are not defined and act as disabled
   assign nom_en       = nom_code != 3'h0;
   assign wr_en        = (wr_code != 3'h0) && (wr_code <= WR_CODE_MAX);
   assign park_en      = park_code != 3'h0;
   assign term_enabled = nom_en || wr_en || park_en;
   assign pin_ok       = nom_en && !self_ref;

   assign x_adj      = ctrl_q[CTRL_PRE2_BIT] ? X_PRE2 : X_PRE1;
   assign half_burst = ctrl_q[CTRL_BL8_BIT] ? HALF_BL8 : HALF_BC4;
   // Latencies below the preamble adjustment clamp at zero
   always_comb begin
      dodtl = 8'h00;
      if ({2'b00, write_latency_q} > x_adj) begin
         dodtl = {2'b00, write_latency_q} - x_adj;
      end
   end
   always_comb begin
      rd_start = 8'h00;
      if ({2'b00, read_latency_q} > x_adj) begin
         rd_start = {2'b00, read_latency_q} - x_adj;
      end
   end
   assign win_len = half_burst + x_adj;

   // AHB-Lite slave: zero wait state, always OKAY
   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   assign hrdata     = rdata_q;
   assign addr_phase = hsel && hready && htrans[1];

   assign status_word = {24'h000000, wr_win, rd_win, rx_en_q, code_q, state_q};

   always_comb begin
      rd_mux = 32'h00000000;
      if (haddr[7:0] == OFF_MODE_ONE) begin
         rd_mux = {14'h0000, mode_register_one_q};
      end else if (haddr[7:0] == OFF_MODE_TWO) begin
         rd_mux = {14'h0000, mode_register_two_q};
      end else if (haddr[7:0] == OFF_MODE_FIVE) begin
         rd_mux = {14'h0000, mode_register_five_q};
      end else if (haddr[7:0] == OFF_CONTROL) begin
         rd_mux = {29'h00000000, ctrl_q};
      end else if (haddr[7:0] == OFF_LATENCY) begin
         rd_mux = {18'h00000, read_latency_q, 2'b00, write_latency_q};
      end else if (haddr[7:0] == OFF_STATUS) begin
         rd_mux = status_word;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_wr_q   <= 1'b0;
         dph_addr_q <= 8'h00;
      end else if (hready) begin
         dph_wr_q   <= addr_phase && hwrite;
         dph_addr_q <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= 32'h00000000;
      end else if (addr_phase && !hwrite) begin
         rdata_q <= rd_mux;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_register_one_q  <= MODE_RST;
         mode_register_two_q  <= MODE_RST;
         mode_register_five_q <= MODE_RST;
         ctrl_q               <= CTRL_RST;
         write_latency_q      <= WL_RST;
         read_latency_q       <= RL_RST;
      end else if (dph_wr_q) begin
         if (dph_addr_q == OFF_MODE_ONE) begin
            mode_register_one_q <= hwdata[MODE_W-1:0];
         end else if (dph_addr_q == OFF_MODE_TWO) begin
            mode_register_two_q <= hwdata[MODE_W-1:0];
         end else if (dph_addr_q == OFF_MODE_FIVE) begin
            mode_register_five_q <= hwdata[MODE_W-1:0];
         end else if (dph_addr_q == OFF_CONTROL) begin
            ctrl_q <= hwdata[CTRL_W-1:0];
         end else if (dph_addr_q == OFF_LATENCY) begin
            write_latency_q <= hwdata[WL_LSB +: LAT_W];
            read_latency_q  <= hwdata[RL_LSB +: LAT_W];
         end
      end
   end

   // Link inputs: two flops each before use
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ck_s1_q  <= 1'b0;
         ck_s2_q  <= 1'b0;
         ck_s3_q  <= 1'b0;
         odt_s1_q <= 1'b0;
         odt_s2_q <= 1'b0;
         cmd_s1_q <= '0;
         cmd_s2_q <= '0;
      end else begin
         ck_s1_q  <= cmd_clk;
         ck_s2_q  <= ck_s1_q;
         ck_s3_q  <= ck_s2_q;
         odt_s1_q <= odt_pin;
         odt_s2_q <= odt_s1_q;
         cmd_s1_q <= cmd;
         cmd_s2_q <= cmd_s1_q;
      end
   end
   // Pin and command pass the same depth as the clock, so their skew is kept
   assign ck_rise = ck_s2_q && !ck_s3_q;

   // Histories: bit n holds the sample taken n command edges ago
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         odt_hist_q <= '0;
         rd_hist_q  <= '0;
         wr_hist_q  <= '0;
      end else if (ck_rise) begin
         odt_hist_q <= {odt_hist_q[HIST_DEPTH-2:0], odt_s2_q && pin_ok};
         rd_hist_q  <= {rd_hist_q[HIST_DEPTH-2:0], cmd_s2_q.rd};
         wr_hist_q  <= {wr_hist_q[HIST_DEPTH-2:0], cmd_s2_q.wr};
      end
   end

   // Windows opened by earlier commands
   always_comb begin
      rd_win = 1'b0;
      wr_win = 1'b0;
      for (int i = 0; i < HIST_DEPTH; i++) begin
         if (rd_hist_q[i] && (8'(i) >= rd_start) && (8'(i) < rd_start + win_len)) begin
            rd_win = 1'b1;
         end
         if (wr_hist_q[i] && (8'(i) >= dodtl) && (8'(i) < dodtl + win_len)) begin
            wr_win = 1'b1;
         end
      end
   end
   assign nom_on = odt_hist_q[dodtl[5:0]] && pin_ok;

   // Termination priority
   always_comb begin
      sel_state = TERM_OFF;
      sel_code  = 3'h0;
      if (self_ref || !term_enabled) begin
         sel_state = TERM_OFF;
      end else if (rd_win) begin
         sel_state = TERM_OFF;
      end else if (wr_win && wr_en) begin
         sel_state = TERM_WRITE;
         sel_code  = wr_code;
      end else if (nom_on && nom_en) begin
         sel_state = TERM_NOM;
         sel_code  = nom_code;
      end else if (park_en) begin
         sel_state = TERM_PARK;
         sel_code  = park_code;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= TERM_OFF;
         code_q  <= 3'h0;
         lanes_q <= '0;
      end else begin
         state_q <= sel_state;
         code_q  <= sel_code;
         lanes_q <= (sel_state != TERM_OFF) ? '1 : '0;
      end
   end

   // Receiver power follows the nominal field outside self refresh
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_en_q <= 1'b0;
      end else begin
         rx_en_q <= pin_ok;
      end
   end

   assign lanes      = lanes_q;
   assign term_state = state_q;
   assign term_code  = code_q;
   assign odt_rx_en  = rx_en_q;

   sr_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      self_ref |=> (state_q == TERM_OFF) && (lanes_q == '0))
      else $error("termination on during self refresh");

   pin_ignored_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ck_rise && !pin_ok) |=> !odt_hist_q[0])
      else $error("pin sampled while it must be ignored");

   rx_power_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (nom_code == 3'h0) |=> !odt_rx_en)
      else $error("pin receiver powered with nominal disabled");

   read_first_a: assert property (@(posedge hclk) disable iff (!hresetn)
      rd_win |=> (state_q == TERM_OFF))
      else $error("termination on inside read window");

   write_term_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (!self_ref && !rd_win && wr_win && wr_en) |=> (state_q == TERM_WRITE) && (code_q == $past(wr_code)))
      else $error("write termination not applied");

   nominal_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (!self_ref && !rd_win && !(wr_win && wr_en) && nom_on) |=> (state_q == TERM_NOM))
      else $error("nominal termination not applied");

   park_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (!self_ref && !rd_win && !(wr_win && wr_en) && !nom_on && park_en) |=> (state_q == TERM_PARK))
      else $error("park termination not applied");

   lanes_all_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_q != TERM_OFF) |-> (lanes == '1))
      else $error("a lane missed the termination");

   capture_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ck_rise |=> (rd_hist_q[0] == $past(cmd_s2_q.rd)) && (wr_hist_q[0] == $past(cmd_s2_q.wr)))
      else $error("command not registered on clock rise");

   odt_latency_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (write_latency_q > 6'h03) |-> (dodtl + x_adj == {2'b00, write_latency_q}))
      else $error("pin latency not write latency minus preamble term");

   write_code_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_q == TERM_WRITE) |-> (code_q != 3'h0) && (code_q <= WR_CODE_MAX))
      else $error("write termination with undefined code");

endmodule

// ### hdl/dtc_pkg.sv
// Package for the DRAM termination control block: register map, fields, types
package dtc_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_MODE_ONE  = 8'h00;
   localparam logic [7:0] OFF_MODE_TWO  = 8'h04;
   localparam logic [7:0] OFF_MODE_FIVE = 8'h08;
   localparam logic [7:0] OFF_CONTROL   = 8'h0c;
   localparam logic [7:0] OFF_LATENCY   = 8'h10;
   localparam logic [7:0] OFF_STATUS    = 8'h14;

   // Mode register layout (address field A[17:0])
   localparam int MODE_W    = 18;
   localparam int FIELD_W   = 3;
   localparam int NOM_LSB   = 8;
   localparam int WR_LSB    = 9;
   localparam int PARK_LSB  = 6;
   localparam logic [2:0] WR_CODE_MAX = 3'h3;

   // Control register bits
   localparam int CTRL_SR_BIT   = 0;
   localparam int CTRL_PRE2_BIT = 1;
   localparam int CTRL_BL8_BIT  = 2;
   localparam int CTRL_W        = 3;

   // Latency register fields
   localparam int LAT_W   = 6;
   localparam int WL_LSB  = 0;
   localparam int RL_LSB  = 8;

   // Status register fields
   localparam int ST_STATE_LSB = 0;
   localparam int ST_CODE_LSB  = 2;
   localparam int ST_RXEN_BIT  = 5;
   localparam int ST_RDWIN_BIT = 6;
   localparam int ST_WRWIN_BIT = 7;

   // Reset values
   localparam logic [MODE_W-1:0] MODE_RST = 18'h00000;
   localparam logic [CTRL_W-1:0] CTRL_RST = 3'h4;
   localparam logic [LAT_W-1:0]  WL_RST   = 6'h09;
   localparam logic [LAT_W-1:0]  RL_RST   = 6'h0b;

   // Preamble adjustment and half burst, in command clock cycles
   localparam logic [7:0] X_PRE1  = 8'h02;
   localparam logic [7:0] X_PRE2  = 8'h03;
   localparam logic [7:0] HALF_BC4 = 8'h02;
   localparam logic [7:0] HALF_BL8 = 8'h04;
   localparam int HIST_DEPTH = 64;

   typedef enum logic [1:0] {
      TERM_OFF,
      TERM_WRITE,
      TERM_NOM,
      TERM_PARK
   } dtc_term_e;

   typedef struct packed {
      logic rd;
      logic wr;
   } dtc_cmd_s;

   typedef struct packed {
      logic [15:0] dq;
      logic [1:0]  upper_data_strobe;
      logic [1:0]  lower_data_strobe;
      logic        upper_data_mask;
      logic        lower_data_mask;
   } dtc_lanes_s;

endpackage

// ### sim/dtc_ctrl_model.sv
// Memory controller model: free-running command clock, termination pin, commands
module dtc_ctrl_model (
   // Command link
   output logic              cmd_clk,
   output logic              odt_pin,
   output dtc_pkg::dtc_cmd_s cmd
);
   timeunit 1ns;
   timeprecision 1ps;
   import dtc_pkg::*;

   logic     pin_nx;
   dtc_cmd_s cmd_nx;

   // Odd start offset keeps the link unrelated in phase to hclk
   initial begin
      cmd_clk = 1'b0;
      odt_pin = 1'b0;
      cmd     = '0;
      pin_nx  = 1'b0;
      cmd_nx  = '0;
      #13;
      forever #200 cmd_clk = ~cmd_clk;
   end

   // Launch on the falling edge so the sampling rise sees settled levels
   always @(negedge cmd_clk) begin
      odt_pin <= pin_nx;
      cmd     <= cmd_nx;
      cmd_nx  <= '0;
   end

   task automatic post(input logic p, input dtc_cmd_s c);
      pin_nx = p;
      cmd_nx = c;
   endtask
endmodule

// ### sim/tb_dram_termination_control.sv
// Testbench for the termination control block
module tb_dram_termination_control;
   timeunit 1ns;
   timeprecision 1ps;
   import dtc_pkg::*;

   logic        hclk, hresetn, hwrite, hreadyout, hresp, cmd_clk, odt_pin, odt_rx_en;
   logic [1:0]  htrans;
   logic [2:0]  term_code;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   dtc_cmd_s    cmd;
   dtc_lanes_s  lanes;
   dtc_term_e   term_state;
   int          miscompares;
   int          samples_checked;

   dtc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .cmd_clk(cmd_clk), .odt_pin(odt_pin), .cmd(cmd),
      .lanes(lanes), .term_state(term_state), .term_code(term_code), .odt_rx_en(odt_rx_en));

   dtc_ctrl_model ctrl (.cmd_clk(cmd_clk), .odt_pin(odt_pin), .cmd(cmd));

   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   task automatic wrap_up();
      $display("Checks made %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         miscompares++;
         wrap_up();
      end
   endtask

   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      haddr  <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'b10;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rdv = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
      // Let the register update reach the outputs
      repeat (2) @(posedge hclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask

   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      chk(n, e, rdv);
   endtask

   // Each step ends six hclk after a command clock rise, before the next rise
   task automatic hold(input int n);
      repeat (n) begin
         @(posedge cmd_clk);
         repeat (6) @(posedge hclk);
      end
   endtask

   task automatic send(input logic p, input logic r, input logic w);
      ctrl.post(p, dtc_cmd_s'{r, w});
      @(negedge cmd_clk);
      hold(1);
   endtask

   task automatic cs(input string n, input dtc_term_e s, input logic [2:0] c);
      chk(n, {30'h0, s}, {30'h0, term_state});
      chk(n, {29'h0, c}, {29'h0, term_code});
      chk(n, (s == TERM_OFF) ? 32'h0 : 32'h003fffff, {10'h0, lanes});
   endtask

   task automatic t_reset();
      cs("reset", TERM_OFF, 3'h0);
      chk("rx_en", 32'h0, {31'h0, odt_rx_en});
      rdc("control", OFF_CONTROL, 32'h4);
      rdc("latency", OFF_LATENCY, 32'h0b09);
      rdc("mode1", OFF_MODE_ONE, 32'h0);
      rdc("status", OFF_STATUS, 32'h0);
      rdc("unmapped", 8'h20, 32'h0);
   endtask

   task automatic t_park();
      wr(OFF_MODE_FIVE, 32'h140);
      wr(OFF_LATENCY, 32'h0806);
      cs("park", TERM_PARK, 3'h5);
      chk("rx_off", 32'h0, {31'h0, odt_rx_en});
      send(1'b1, 1'b0, 1'b0);
      hold(6);
      cs("pin_ignored", TERM_PARK, 3'h5);
      send(1'b0, 1'b0, 1'b0);
   endtask

   // Pin latency is write latency less the preamble adjustment
   task automatic t_nominal(input logic [31:0] ctl, input int d);
      wr(OFF_MODE_ONE, 32'h300);
      wr(OFF_CONTROL, ctl);
      chk("rx_on", 32'h1, {31'h0, odt_rx_en});
      send(1'b1, 1'b0, 1'b0);
      hold(d - 1);
      cs("nom_early", TERM_PARK, 3'h5);
      hold(1);
      cs("nom_on", TERM_NOM, 3'h3);
      rdc("status", OFF_STATUS, 32'h2e);
      send(1'b0, 1'b0, 1'b0);
      hold(d - 1);
      cs("nom_hold", TERM_NOM, 3'h3);
      hold(1);
      cs("park_back", TERM_PARK, 3'h5);
      wr(OFF_CONTROL, 32'h4);
   endtask

   task automatic t_write();
      wr(OFF_MODE_TWO, 32'h400);
      send(1'b0, 1'b0, 1'b1);
      hold(3);
      cs("wr_early", TERM_PARK, 3'h5);
      hold(1);
      cs("wr_on", TERM_WRITE, 3'h2);
      hold(5);
      cs("wr_last", TERM_WRITE, 3'h2);
      hold(1);
      cs("wr_end", TERM_PARK, 3'h5);
      send(1'b1, 1'b0, 1'b0);
      hold(4);
      send(1'b1, 1'b0, 1'b1);
      hold(4);
      cs("wr_over_nom", TERM_WRITE, 3'h2);
      hold(6);
      cs("nom_after_wr", TERM_NOM, 3'h3);
      wr(OFF_MODE_TWO, 32'h800);
      send(1'b1, 1'b0, 1'b1);
      hold(4);
      cs("wr_code4", TERM_NOM, 3'h3);
   endtask

   // Read turns termination off from RL-X for half burst plus X rises
   task automatic t_read(input logic [31:0] ctl, input int d, input int len);
      wr(OFF_CONTROL, ctl);
      send(1'b1, 1'b1, 1'b0);
      hold(d - 1);
      cs("rd_early", TERM_NOM, 3'h3);
      hold(1);
      cs("rd_off", TERM_OFF, 3'h0);
      hold(len - 1);
      cs("rd_last", TERM_OFF, 3'h0);
      hold(1);
      cs("rd_end", TERM_NOM, 3'h3);
   endtask

   task automatic t_selfref();
      wr(OFF_CONTROL, 32'h5);
      cs("sr_entry", TERM_OFF, 3'h0);
      send(1'b1, 1'b0, 1'b1);
      hold(8);
      cs("sr_hold", TERM_OFF, 3'h0);
      wr(OFF_CONTROL, 32'h4);
      // Pin samples taken in self refresh must not come back after exit
      hold(3);
      cs("sr_pin_dropped", TERM_PARK, 3'h5);
      hold(1);
      cs("sr_exit", TERM_NOM, 3'h3);
   endtask

   task automatic t_disabled();
      wr(OFF_MODE_ONE, 32'h0);
      wr(OFF_MODE_TWO, 32'h0);
      wr(OFF_MODE_FIVE, 32'h0);
      cs("all_off", TERM_OFF, 3'h0);
      chk("rx_off2", 32'h0, {31'h0, odt_rx_en});
      rdc("mode5", OFF_MODE_FIVE, 32'h0);
   endtask

   initial begin
      hresetn = 1'b0;
      haddr   = '0;
      htrans  = 2'b00;
      hwrite  = 1'b0;
      hwdata  = '0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_park();
      t_nominal(32'h4, 4);
      t_nominal(32'h6, 3);
      t_write();
      wr(OFF_MODE_TWO, 32'h400);
      t_read(32'h4, 6, 6);
      t_read(32'h0, 6, 4);
      t_read(32'h6, 5, 7);
      t_read(32'h2, 5, 5);
      t_selfref();
      t_disabled();
      wrap_up();
   end

   initial begin
      #2000000;
      miscompares++;
      wrap_up();
   end
endmodule
